// File: tb/sbmp_bus_monitor.sv
// Purpose: bus-side checks between master port and slave end
// Assumes: one clock domain; lines active low, pulled high
// Notes: sees resolved lines and the master's enables only
`timescale 1ns/1ns
`default_nettype none
module sbmp_bus_monitor
   import sbmp_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic bus_clk_n,
   input wire logic priority_grant_in,
   input wire logic busy_oe,
   input wire logic ext_busy_n,
   input wire logic addr_oe,
   input wire logic [ADDR_W-1:0] addr_n,
   input wire logic data_m_oe,
   input wire logic mem_read_cmd_n,
   input wire logic mem_write_cmd_n,
   input wire logic io_read_cmd_n,
   input wire logic io_write_cmd_n,
   input wire logic transfer_ack_n,
   input wire logic early_ack_n
);
   // commands true-level, bit order as the cmd vector
   wire [3:0] cmd_on = ~{io_write_cmd_n, io_read_cmd_n, mem_write_cmd_n, mem_read_cmd_n};
   wire cmd_act = |cmd_on;
   wire acked = !(transfer_ack_n && early_ack_n);
   default clocking mon_cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   // command handshake order
   AST_CMD_HOLD: assert property (cmd_act && !acked |=> cmd_act)
      else $error("command dropped early");
   AST_CMD_END: assert property (cmd_act && acked |-> ##[1:5] !cmd_act)
      else $error("command kept after ack");
   AST_ADDR_FIRST: assert property ($rose(cmd_act) |-> $past(addr_oe) && addr_oe)
      else $error("no address before command");
   AST_ADDR_STABLE: assert property (cmd_act |-> addr_oe && $stable(addr_n))
      else $error("address moved in command");
   AST_ONE_CMD: assert property ($onehot0(cmd_on))
      else $error("two commands at once");
   AST_WR_DATA: assert property (cmd_on[CMD_MWR_BIT] || cmd_on[CMD_IOWR_BIT] |-> data_m_oe)
      else $error("write without data");
   AST_RD_FREE: assert property (cmd_on[CMD_MRD_BIT] || cmd_on[CMD_IORD_BIT] |-> !data_m_oe)
      else $error("master drives read data");
   // release and ownership around arbitration
   AST_HOLD_FREE: assert property (!busy_oe |-> !addr_oe && !data_m_oe && !cmd_act)
      else $error("drivers on while released");
   AST_HOLD_ENTER: assert property ((!priority_grant_in && !addr_oe) [*5] |-> !busy_oe)
      else $error("bus not given up");
   AST_HOLD_STAY: assert property ((!busy_oe && !ext_busy_n) [*3] |=> !busy_oe)
      else $error("bus taken while busy");
   // divided bus clock, half period of one cycle
   AST_BCLK_LOW: assert property (!bus_clk_n |=> bus_clk_n)
      else $error("bus clock low too long");
   AST_BCLK_HIGH: assert property (bus_clk_n [*2] |=> !bus_clk_n)
      else $error("bus clock high too long");
endmodule
`default_nettype wire

// File: tb/system_bus_master_port_test.sv
// Purpose: master port and slave end joined over one bus
// Assumes: slave memory aliases on the low 8 address bits
// Notes: wire values checked while a command line is low
`timescale 1ns/1ns
`default_nettype none
module system_bus_master_port_test
   import sbmp_pkg::*;
;
   logic clk, rstn, init_req, req_valid, early_ack_en, grant, ext_busy_n;
   logic [1:0] req_cmd;
   logic [ADDR_W-1:0] req_addr;
   logic [DATA_W-1:0] req_wdata, io_in, resp_rdata, io_out;
   logic req_ready, resp_valid, cpu_hold_ack_n;
   int error_cnt = 0;
   int checks_done = 0;
   sbmp_bus_if bus ();
   // the other master only shows on grant and busy
   assign bus.priority_grant_in = grant;
   assign bus.ext_busy_n = ext_busy_n;
   wire [3:0] cmd_lines = {bus.io_write_cmd_n, bus.io_read_cmd_n,
      bus.mem_write_cmd_n, bus.mem_read_cmd_n};
   sbmp_master sbmp_master_i (.clk(clk), .rstn(rstn), .bus(bus.master), .init_req(init_req),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
      .req_wdata(req_wdata), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
      .cpu_hold_ack_n(cpu_hold_ack_n));
   sbmp_slave sbmp_slave_i (.clk(clk), .rstn(rstn), .bus(bus.slave),
      .early_ack_en(early_ack_en), .io_in(io_in), .io_out(io_out));
   sbmp_bus_monitor sbmp_bus_monitor_i (.clk(clk), .rstn(rstn), .bus_clk_n(bus.bus_clk_n),
      .priority_grant_in(bus.priority_grant_in), .busy_oe(bus.busy_oe),
      .ext_busy_n(bus.ext_busy_n), .addr_oe(bus.addr_oe), .addr_n(bus.addr_n),
      .data_m_oe(bus.data_m_oe), .mem_read_cmd_n(bus.mem_read_cmd_n),
      .mem_write_cmd_n(bus.mem_write_cmd_n), .io_read_cmd_n(bus.io_read_cmd_n),
      .io_write_cmd_n(bus.io_write_cmd_n), .transfer_ack_n(bus.transfer_ack_n),
      .early_ack_n(bus.early_ack_n));
   // 20 MHz own clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // a wait that ran out ends the run at once
   task automatic give_up(input string what);
      error_cnt++;
      $display("wrong value at %0t: no %s", $time, what);
      end_of_test();
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   task automatic wait_hold(input logic lvl);
      int n;
      for (n = 0; n < 40 && cpu_hold_ack_n !== lvl; n++)
         @(posedge clk) #1;
      if (n == 40)
         give_up("hold change");
   endtask
   // one whole transfer; wire checked every cycle of it that a command line is low
   task automatic xfer(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d,
      input logic [7:0] e);
      logic [15:0] na;
      logic [7:0] nd;
      logic [7:0] ne;
      logic [3:0] nc;
      logic ea;
      int n;
      na = ~a;
      nd = ~d;
      ne = ~e;
      nc = ~(4'h1 << c);
      ea = 1'b0;
      @(posedge clk);
      req_cmd <= c;
      req_addr <= a;
      req_wdata <= d;
      req_valid <= 1'b1;
      #1;
      for (n = 0; n < 40 && req_ready !== 1'b1; n++)
         @(posedge clk) #1;
      if (n == 40)
         give_up("take");
      @(posedge clk);
      req_valid <= 1'b0;
      for (n = 0; n < 40 && resp_valid !== 1'b1; n++)
      begin
         @(posedge clk) #1;
         if (cmd_lines !== 4'hf)
         begin
            check(cmd_lines, nc);
            check(bus.addr_n, na);
            check(bus.addr_msb_n, na[15]);
            if (c[0])
            begin
               check(bus.data_n, nd);
               check(bus.data_msb_n, nd[7]);
            end
         end
         if (!c[0] && bus.transfer_ack_n === 1'b0)
            check(bus.data_n, ne);
         if (bus.early_ack_n === 1'b0)
            ea = 1'b1;
      end
      if (n == 40)
         give_up("answer");
      if (!c[0])
         check(resp_rdata, e);
      check(ea, early_ack_en && !c[1]);
      // early acknowledge saves the wait for the late acknowledge on memory reads
      check(16'(n), (c[0] || (early_ack_en && !c[1])) ? 16'h0007 : 16'h0008);
   endtask
   initial
   begin
      rstn = 1'b0;
      init_req = 1'b0;
      req_valid = 1'b0;
      req_cmd = 2'h0;
      req_addr = 16'h0000;
      req_wdata = 8'h00;
      early_ack_en = 1'b0;
      grant = 1'b1;
      ext_busy_n = 1'b1;
      io_in = 8'hc3;
      repeat (19) @(posedge clk);
      check(bus.init_n, 1'b0);
      check(io_out, 8'h00);
      @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(bus.init_n, 1'b1);
      done("reset");
      // aliasing: top and bottom of the range meet low cells
      xfer(SBMP_MEM_WR, 16'hffff, 8'ha5, 8'h00);
      xfer(SBMP_MEM_WR, 16'h0000, 8'h5a, 8'h00);
      xfer(SBMP_MEM_RD, 16'h00ff, 8'h00, 8'ha5);
      xfer(SBMP_MEM_RD, 16'h8000, 8'h00, 8'h5a);
      done("memory");
      xfer(SBMP_IO_WR, 16'h00f0, 8'h3c, 8'h00);
      check(io_out, 8'h3c);
      xfer(SBMP_IO_RD, 16'h0001, 8'h00, 8'hc3);
      done("io");
      @(posedge clk);
      early_ack_en <= 1'b1;
      io_in <= 8'h69;
      xfer(SBMP_MEM_WR, 16'h1234, 8'h81, 8'h00);
      xfer(SBMP_MEM_RD, 16'h1234, 8'h00, 8'h81);
      xfer(SBMP_IO_RD, 16'h0002, 8'h00, 8'h69);
      @(posedge clk);
      early_ack_en <= 1'b0;
      done("early");
      // higher master takes over, then holds busy
      @(posedge clk);
      grant <= 1'b0;
      wait_hold(1'b0);
      check(bus.busy_n, 1'b1);
      check(bus.addr_n, 16'hffff);
      check(cmd_lines, 4'hf);
      check(req_ready, 1'b0);
      @(posedge clk);
      ext_busy_n <= 1'b0;
      grant <= 1'b1;
      repeat (10) @(posedge clk);
      #1;
      check(cpu_hold_ack_n, 1'b0);
      @(posedge clk);
      ext_busy_n <= 1'b1;
      wait_hold(1'b1);
      check(bus.busy_n, 1'b0);
      xfer(SBMP_MEM_RD, 16'h00ff, 8'h00, 8'ha5);
      done("arbitration");
      xfer(SBMP_IO_WR, 16'h0042, 8'h99, 8'h00);
      check(io_out, 8'h99);
      @(posedge clk);
      init_req <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      check(bus.init_n, 1'b0);
      @(posedge clk);
      init_req <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check(io_out, 8'h00);
      check(bus.init_n, 1'b1);
      done("init");
      end_of_test();
   end
endmodule
`default_nettype wire

// File: verilog/sbmp_bus_if.sv
// Purpose: the shared system bus, resolving open-drain active-low lines
// Assumes: an undriven line pulls high; drivers are wired-AND
// Notes: ext_busy_n stands for any other master on the busy line
`timescale 1ns/1ns
`default_nettype none
interface sbmp_bus_if;
   import sbmp_pkg::*;
   logic bus_clk_o, bus_clk_oe, bus_clk_n;
   logic init_o, init_oe, init_n;
   logic priority_grant_in;
   logic busy_o, busy_oe, ext_busy_n, busy_n;
   logic [ADDR_W-1:0] addr_o, addr_n;
   logic addr_oe;
   logic [3:0] cmd_o;
   logic cmd_oe;
   logic mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n;
   logic [DATA_W-1:0] data_m_o, data_s_o, data_n;
   logic data_m_oe, data_s_oe;
   logic transfer_ack_o, early_ack_o, ack_oe;
   logic transfer_ack_n, early_ack_n;
   logic addr_msb_n, data_msb_n;
   // line resolution, pull-up when released
   assign bus_clk_n = bus_clk_oe ? bus_clk_o : 1'b1;
   assign init_n = init_oe ? init_o : 1'b1;
   assign busy_n = (busy_oe ? busy_o : 1'b1) & ext_busy_n;
   assign addr_n = addr_oe ? addr_o : ADDR_IDLE_N;
   assign mem_read_cmd_n = cmd_oe ? cmd_o[CMD_MRD_BIT] : 1'b1;
   assign mem_write_cmd_n = cmd_oe ? cmd_o[CMD_MWR_BIT] : 1'b1;
   assign io_read_cmd_n = cmd_oe ? cmd_o[CMD_IORD_BIT] : 1'b1;
   assign io_write_cmd_n = cmd_oe ? cmd_o[CMD_IOWR_BIT] : 1'b1;
   assign data_n = (data_m_oe ? data_m_o : DATA_IDLE_N) & (data_s_oe ? data_s_o : DATA_IDLE_N);
   assign transfer_ack_n = ack_oe ? transfer_ack_o : 1'b1;
   assign early_ack_n = ack_oe ? early_ack_o : 1'b1;
   assign addr_msb_n = addr_n[ADDR_W-1];
   assign data_msb_n = data_n[DATA_W-1];
   modport master (
      output bus_clk_o, bus_clk_oe, init_o, init_oe, busy_o, busy_oe,
      output addr_o, addr_oe, cmd_o, cmd_oe, data_m_o, data_m_oe,
      input priority_grant_in, busy_n, data_n, transfer_ack_n, early_ack_n
   );
   modport slave (
      input bus_clk_n, init_n, addr_n, data_n,
      input mem_read_cmd_n, mem_write_cmd_n, io_read_cmd_n, io_write_cmd_n,
      output data_s_o, data_s_oe, transfer_ack_o, early_ack_o, ack_oe
   );
endinterface
`default_nettype wire

// File: verilog/sbmp_master.sv
// Purpose: board end of the system bus; issues memory and I/O commands
// Assumes: bus inputs are asynchronous and pass two flip-flops before use
// Notes: bus clock is generated here but no handshake depends on its edges
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - handshakes run on own clock, not bus clock
// - drive bus clock from divider when supplying
// - survive slowed, stopped or stepped bus clock
// - active-low init returns modules to known state
// - priority withdrawn: suspend requests, release address, data, command and busy drivers
// - busy line driven from hold acknowledge
// - no bus takeover while busy asserted
// - memory read: address first, slave drives data
// - memory write: address and data, slave stores
// - I/O read: port address, port drives data
// - I/O write: port address and data driven
// - slave acknowledges once data placed or taken
// - slave may early-acknowledge memory read
// - sixteen-bit address, 65,536 byte range
// - slave may early-acknowledge memory writes too
// - lines active low, highest bit most significant
// - lowest priority, no priority output chained
module sbmp_master
   import sbmp_pkg::*;
#(
   parameter bit DRIVE_BCLK = 1'b1
)(
   input wire logic clk,
   input wire logic rstn,
   sbmp_bus_if.master bus,
   input wire logic init_req,
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [1:0] req_cmd,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic resp_valid,
   output logic [DATA_W-1:0] resp_rdata,
   output logic cpu_hold_ack_n
);
   localparam int SYNC_W = DATA_W + 4;

   sbmp_mst_e state_r, state_nxt;
   logic [SYNC_W-1:0] sync1_r, sync2_r;
   logic [BCLK_CNT_W-1:0] bclk_cnt_r, bclk_cnt_nxt;
   logic bclk_r, bclk_nxt;
   logic [ADDR_W-1:0] addr_n_r, addr_n_nxt;
   logic [DATA_W-1:0] wdata_n_r, wdata_n_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic [1:0] cmd_r, cmd_nxt;
   logic resp_r, resp_nxt;
   logic init_r;

   // synchronised views of the bus
   logic grant_s;
   logic busy_s_n;
   logic xfer_ack_s_n;
   logic early_ack_s_n;
   logic [DATA_W-1:0] data_s_n;
   assign grant_s = sync2_r[SYNC_W-1];
   assign busy_s_n = sync2_r[SYNC_W-2];
   assign xfer_ack_s_n = sync2_r[SYNC_W-3];
   assign early_ack_s_n = sync2_r[SYNC_W-4];
   assign data_s_n = sync2_r[DATA_W-1:0];

   // state decode
   logic st_idle, st_setup, st_cmd, st_done, st_hold;
   assign st_idle = (state_r == SBMP_M_IDLE);
   assign st_setup = (state_r == SBMP_M_SETUP);
   assign st_cmd = (state_r == SBMP_M_CMD);
   assign st_done = (state_r == SBMP_M_DONE);
   assign st_hold = (state_r == SBMP_M_HOLD);

   logic any_ack;
   logic acks_clear;
   logic in_xfer;
   logic is_write;
   logic take_req;
   assign any_ack = !xfer_ack_s_n || !early_ack_s_n;
   assign acks_clear = xfer_ack_s_n && early_ack_s_n;
   assign in_xfer = st_setup || st_cmd || st_done;
   assign is_write = (cmd_r == SBMP_MEM_WR) || (cmd_r == SBMP_IO_WR);
   assign take_req = st_idle && grant_s && req_valid;

   // two flops on every bus input, nothing reads the first stage
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= {bus.priority_grant_in, bus.busy_n, bus.transfer_ack_n,
                     bus.early_ack_n, bus.data_n};
         sync2_r <= sync1_r;
      end
   end

   // bus clock divider; nominal period rounds to whole own-clock cycles
   always_comb
   begin
      bclk_cnt_nxt = bclk_cnt_r + 1'b1;
      bclk_nxt = bclk_r;
      if (bclk_cnt_r == BCLK_HALF_LAST)
      begin
         bclk_cnt_nxt = '0;
         bclk_nxt = !bclk_r;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bclk_cnt_r <= '0;
         bclk_r <= 1'b1;
      end
      else
      begin
         bclk_cnt_r <= bclk_cnt_nxt;
         bclk_r <= bclk_nxt;
      end
   end

   // init held low through reset and while software asks for it
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         init_r <= 1'b0;
      else
         init_r <= !init_req;
   end

   // transfer sequencer; every step waits on levels, never on bus clock edges
   always_comb
   begin
      state_nxt = state_r;
      addr_n_nxt = addr_n_r;
      wdata_n_nxt = wdata_n_r;
      cmd_nxt = cmd_r;
      rdata_nxt = rdata_r;
      resp_nxt = 1'b0;
      case (state_r)
         SBMP_M_IDLE:
         begin
            if (!grant_s)
               state_nxt = SBMP_M_HOLD;
            else if (take_req)
            begin
               addr_n_nxt = ~req_addr;
               wdata_n_nxt = ~req_wdata;
               cmd_nxt = req_cmd;
               state_nxt = SBMP_M_SETUP;
            end
         end
         SBMP_M_SETUP:
            state_nxt = SBMP_M_CMD;
         SBMP_M_CMD:
         begin
            if (any_ack)
            begin
               rdata_nxt = ~data_s_n;
               resp_nxt = 1'b1;
               state_nxt = SBMP_M_DONE;
            end
         end
         SBMP_M_DONE:
         begin
            if (acks_clear)
               state_nxt = SBMP_M_IDLE;
         end
         SBMP_M_HOLD:
         begin
            if (grant_s && busy_s_n)
               state_nxt = SBMP_M_IDLE;
         end
         default:
            state_nxt = SBMP_M_IDLE;
      endcase
   end

   // a stalled bus clock changes nothing here, so no state is lost
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= SBMP_M_IDLE;
         addr_n_r <= ADDR_IDLE_N;
         wdata_n_r <= DATA_IDLE_N;
         cmd_r <= SBMP_MEM_RD;
         rdata_r <= '0;
         resp_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         addr_n_r <= addr_n_nxt;
         wdata_n_r <= wdata_n_nxt;
         cmd_r <= cmd_nxt;
         rdata_r <= rdata_nxt;
         resp_r <= resp_nxt;
      end
   end

   // command lines low only in the command state, one per kind
   logic [3:0] cmd_lines_n;
   assign cmd_lines_n[CMD_MRD_BIT] = !(st_cmd && cmd_r == SBMP_MEM_RD);
   assign cmd_lines_n[CMD_MWR_BIT] = !(st_cmd && cmd_r == SBMP_MEM_WR);
   assign cmd_lines_n[CMD_IORD_BIT] = !(st_cmd && cmd_r == SBMP_IO_RD);
   assign cmd_lines_n[CMD_IOWR_BIT] = !(st_cmd && cmd_r == SBMP_IO_WR);

   // bus drivers; address, data, command and busy let go while holding
   assign bus.bus_clk_o = bclk_r;
   assign bus.bus_clk_oe = DRIVE_BCLK;
   assign bus.init_o = init_r;
   assign bus.init_oe = 1'b1;
   assign bus.addr_o = addr_n_r;
   assign bus.addr_oe = in_xfer;
   assign bus.cmd_o = cmd_lines_n;
   assign bus.cmd_oe = !st_hold;
   assign bus.data_m_o = wdata_n_r;
   assign bus.data_m_oe = in_xfer && is_write;
   assign cpu_hold_ack_n = !st_hold;
   assign bus.busy_o = 1'b0;
   assign bus.busy_oe = cpu_hold_ack_n;

   // user side
   assign req_ready = st_idle && grant_s;
   assign resp_valid = resp_r;
   assign resp_rdata = rdata_r;
endmodule
`default_nettype wire

// File: verilog/sbmp_pkg.sv
// Purpose: shared constants and types for the system bus master port and slave end
// Assumes: active-low bus lines, 16-bit address, 8-bit data
// Notes: bus clock figures are the nominal ones; the divider rounds to whole cycles
package sbmp_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   // own clock and bus clock timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int BCLK_PERIOD_NS = 110;
   localparam int BCLK_HALF_RAW = (BCLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
   localparam int BCLK_HALF_CYC = (BCLK_HALF_RAW < 1) ? 1 : BCLK_HALF_RAW;
   localparam int BCLK_CNT_W = 4;
   localparam logic [BCLK_CNT_W-1:0] BCLK_HALF_LAST = BCLK_CNT_W'(BCLK_HALF_CYC - 1);
   // reset values
   localparam logic [ADDR_W-1:0] ADDR_IDLE_N = 16'hffff;
   localparam logic [DATA_W-1:0] DATA_IDLE_N = 8'hff;
   localparam logic [DATA_W-1:0] IO_OUT_RESET = 8'h00;
   // command field positions in the cmd vector
   localparam int CMD_MRD_BIT = 0;
   localparam int CMD_MWR_BIT = 1;
   localparam int CMD_IORD_BIT = 2;
   localparam int CMD_IOWR_BIT = 3;
   typedef enum logic [1:0] {
      SBMP_MEM_RD = 2'h0,
      SBMP_MEM_WR = 2'h1,
      SBMP_IO_RD = 2'h2,
      SBMP_IO_WR = 2'h3
   } sbmp_cmd_e;
   typedef enum logic [4:0] {
      SBMP_M_IDLE = 5'h01,
      SBMP_M_SETUP = 5'h02,
      SBMP_M_CMD = 5'h04,
      SBMP_M_DONE = 5'h08,
      SBMP_M_HOLD = 5'h10
   } sbmp_mst_e;
   typedef enum logic [2:0] {
      SBMP_S_IDLE = 3'h1,
      SBMP_S_DRIVE = 3'h2,
      SBMP_S_ACK = 3'h4
   } sbmp_slv_e;
endpackage

// File: verilog/sbmp_slave.sv
// Purpose: memory and I/O slave end of the system bus
// Assumes: address and data settle before the command; all pass two flops alike
// Notes: memory aliases over the whole range; all I/O addresses reach one port
`timescale 1ns/1ns
`default_nettype none
module sbmp_slave
   import sbmp_pkg::*;
#(
   parameter int MEM_AW = 8
)(
   input wire logic clk,
   input wire logic rstn,
   sbmp_bus_if.slave bus,
   input wire logic early_ack_en,
   input wire logic [DATA_W-1:0] io_in,
   output logic [DATA_W-1:0] io_out
);
   localparam int SYNC_W = 1 + 4 + ADDR_W + DATA_W;

   logic [DATA_W-1:0] mem [0:(1<<MEM_AW)-1];
   logic [SYNC_W-1:0] sync1_r, sync2_r;
   sbmp_slv_e state_r, state_nxt;
   logic [DATA_W-1:0] rd_n_r, rd_n_nxt;
   logic [DATA_W-1:0] io_out_r, io_out_nxt;
   logic is_read_r, is_read_nxt;

   // synchronised bus views
   logic init_s_n;
   logic [3:0] cmd_s_n;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] wdata_s;
   logic [MEM_AW-1:0] idx;
   assign init_s_n = sync2_r[SYNC_W-1];
   assign cmd_s_n = sync2_r[SYNC_W-2 -: 4];
   assign addr_s = ~sync2_r[DATA_W +: ADDR_W];
   assign wdata_s = ~sync2_r[DATA_W-1:0];
   assign idx = addr_s[MEM_AW-1:0];

   logic any_cmd;
   logic mem_wr;
   logic io_wr;
   logic st_idle, st_drive, st_ack;
   assign any_cmd = !(&cmd_s_n);
   assign st_idle = (state_r == SBMP_S_IDLE);
   assign st_drive = (state_r == SBMP_S_DRIVE);
   assign st_ack = (state_r == SBMP_S_ACK);
   assign mem_wr = st_idle && !cmd_s_n[CMD_MWR_BIT];
   assign io_wr = st_idle && !cmd_s_n[CMD_IOWR_BIT];

   // two flops on every bus input except the unused bus clock
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_r <= '1;
         sync2_r <= '1;
      end
      else
      begin
         sync1_r <= {bus.init_n, bus.io_write_cmd_n, bus.io_read_cmd_n,
                     bus.mem_write_cmd_n, bus.mem_read_cmd_n, bus.addr_n, bus.data_n};
         sync2_r <= sync1_r;
      end
   end

   // responder: drive read data a cycle before the transfer acknowledge
   always_comb
   begin
      state_nxt = state_r;
      rd_n_nxt = rd_n_r;
      io_out_nxt = io_out_r;
      is_read_nxt = is_read_r;
      case (state_r)
         SBMP_S_IDLE:
         begin
            if (!cmd_s_n[CMD_MRD_BIT])
            begin
               rd_n_nxt = ~mem[idx];
               is_read_nxt = 1'b1;
               state_nxt = SBMP_S_DRIVE;
            end
            else if (!cmd_s_n[CMD_IORD_BIT])
            begin
               rd_n_nxt = ~io_in;
               is_read_nxt = 1'b1;
               state_nxt = SBMP_S_DRIVE;
            end
            else if (any_cmd)
            begin
               if (io_wr)
                  io_out_nxt = wdata_s;
               is_read_nxt = 1'b0;
               state_nxt = SBMP_S_ACK;
            end
         end
         SBMP_S_DRIVE:
            state_nxt = SBMP_S_ACK;
         SBMP_S_ACK:
         begin
            if (!any_cmd)
               state_nxt = SBMP_S_IDLE;
         end
         default:
            state_nxt = SBMP_S_IDLE;
      endcase
      if (!init_s_n)
      begin
         state_nxt = SBMP_S_IDLE;
         io_out_nxt = IO_OUT_RESET;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= SBMP_S_IDLE;
         rd_n_r <= DATA_IDLE_N;
         io_out_r <= IO_OUT_RESET;
         is_read_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         rd_n_r <= rd_n_nxt;
         io_out_r <= io_out_nxt;
         is_read_r <= is_read_nxt;
      end
   end

   // storage has no reset; contents survive init
   always_ff @(posedge clk)
   begin
      if (mem_wr && init_s_n)
         mem[idx] <= wdata_s;
   end

   // early acknowledge only for memory cycles, up with the data
   logic mem_cycle;
   assign mem_cycle = !cmd_s_n[CMD_MRD_BIT] || !cmd_s_n[CMD_MWR_BIT];
   assign bus.data_s_o = rd_n_r;
   assign bus.data_s_oe = is_read_r && (st_drive || st_ack);
   assign bus.transfer_ack_o = !st_ack;
   assign bus.early_ack_o = !(early_ack_en && mem_cycle && (st_drive || st_ack));
   assign bus.ack_oe = st_drive || st_ack;
   assign io_out = io_out_r;
endmodule
`default_nettype wire
